/* File: hw/cap_pkg.sv */
/*
 Constants for the counter array PWM unit: register addresses on the
 special function register bus, field positions, reset values, codes.
 Assumes a byte-wide register bus with one address per register.
*/
package cap_pkg;
	// Register addresses, index 0 for block 0 and 1 for block 1
	localparam logic [1:0][7:0] A_CNTL = {8'hba, 8'ha2};
	localparam logic [1:0][7:0] A_CNTH = {8'hbb, 8'ha3};
	localparam logic [1:0][7:0] A_CTL  = {8'hbc, 8'ha4};
	localparam logic [1:0][7:0] A_PER  = {8'hc7, 8'hb4};
	localparam logic [1:0][7:0] A_PSC  = {8'hfc, 8'hfb};
	localparam logic [7:0]      A_STA  = 8'ha5;
	// Per module addresses, modules 0..2 in block 0 and 3..5 in block 1
	localparam logic [5:0][7:0] A_MODE = {8'hbf, 8'hbe, 8'hbd, 8'hab, 8'haa, 8'ha9};
	localparam logic [5:0][7:0] A_CMPL = {8'hc5, 8'hc3, 8'hc1, 8'hb2, 8'haf, 8'hac};
	localparam logic [5:0][7:0] A_CMPH = {8'hc6, 8'hc4, 8'hc2, 8'hb3, 8'hb1, 8'had};
	// Reset values
	localparam logic [7:0] CTL_RST  = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] PSC_RST  = 8'h10;
	// Control register fields
	localparam int CTL_ALL  = 7;
	localparam int CTL_RUN  = 6;
	localparam int CTL_IRQ  = 5;
	localparam int CTL_IDLE = 4;
	localparam int CTL_TEN  = 2;
	localparam int CTL_CLK  = 0;
	// Status, mode and prescaler fields
	localparam logic [1:0][2:0] STA_OVF = {3'd7, 3'd3};
	localparam int MODE_ECMP = 6;
	localparam int MODE_PWM  = 0;
	localparam int PSC_CE    = 4;
	// Clock select codes
	localparam logic [1:0] CLK_PSC = 2'h0;
	localparam logic [1:0] CLK_T0  = 2'h1;
	localparam logic [1:0] CLK_EXT = 2'h2;
	// PWM mode codes in the mode register
	localparam logic [1:0] PWM_OFF  = 2'h0;
	localparam logic [1:0] PWM_FIX8 = 2'h1;
	localparam logic [1:0] PWM_PRG8 = 2'h2;
	localparam logic [1:0] PWM_WIDE = 2'h3;
	// Ten bit wide mode keeps this many counter bits
	localparam int TEN_W = 10;
	localparam logic [9:0] TEN_MAX = 10'h3ff;
endpackage

/* File: hw/cap_pwm_unit.sv */
/*
 Two counter blocks of three PWM modules each, with their registers on
 the special function register bus. Assumes bus strobes and the timer 0
 overflow pulse are synchronous to mclk; external clock pins are synchronised inside.
*/
// Functional notes
// - 8-bit fixed PWM period is the counter low byte wrap, modulo 256.
// - 8-bit fixed PWM output high while low byte >= active duty.
// - On low byte wrap, copy compare high byte into compare low byte.
// - Programmable PWM: period match clears counter, reloads holding regs.
// - One period register per block, each module keeps its own duty.
// - 16-bit PWM output high while counter >= compare value.
// - 16-bit PWM output goes low on counter overflow.
// - 10-bit PWM ignores upper six bits of counter and compare high.
// - 10-bit PWM: high at or above compare, low on 10-bit overflow.
// - Compare low write clears comparator enable, high write sets it.
// - Compare 0 gives full duty; comparator disabled gives zero duty.
// - Block 0 bit 7 runs both counters, overriding run bits.
// - Bit 6 is counter run control, changed only by software.
// - Bit 5 enables the overflow interrupt request.
// - Bit 4 set halts the block while the CPU idles.
// - Clock select: prescaler, timer 0 overflow, or external pin.
// - Overflow flag set on rollover; software may set, only software clears.
// - Prescaler divides by two to the power of its four-bit field.
`timescale 1ns/10ps
module cap_pwm_unit (
	input  wire logic       mclk,
	input  wire logic       nrst,
	input  wire logic [7:0] sfr_addr,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	output logic      [7:0] sfr_rdata,
	input  wire logic       cpu_idle,
	input  wire logic       timer0_ovf,
	input  wire logic [1:0] ext_clk_pin,
	output logic      [5:0] pwm_output_pin,
	output logic            overflow_irq
);
	// Prescaler mask: low ps bits set, so a tick comes every 2**ps cycles
	function automatic logic [14:0] psc_mask(input logic [3:0] ps);
		psc_mask = 15'((16'h1 << ps) - 16'h1);
	endfunction

	logic [1:0][7:0]  block_control_reg;
	logic [1:0][15:0] cnt_reg;
	logic [1:0][7:0]  period_reg;
	logic [1:0][7:0]  period_act_reg;
	logic [1:0][7:0]  psc_cfg_reg;
	logic [1:0][14:0] psc_cnt_reg;
	logic [1:0]       overflow_flag_reg;
	logic [5:0][7:0]  mode_reg;
	logic [5:0][7:0]  cmp_lo_reg;
	logic [5:0][7:0]  cmp_hi_reg;
	logic [1:0]       ext_s1_reg;
	logic [1:0]       ext_s2_reg;
	logic [1:0]       ext_prev_reg;
	logic [1:0]       tick;
	logic [1:0]       run;
	logic [1:0]       prog;
	logic [1:0]       match;
	logic [1:0]       lo_wrap;
	logic [1:0]       ovf_evt;
	logic [7:0]       rd_mux;

	// External clock pins: two-stage sync, then a rising edge detect
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ext_s1_reg   <= 2'h0;
			ext_s2_reg   <= 2'h0;
			ext_prev_reg <= 2'h0;
		end else begin
			ext_s1_reg   <= ext_clk_pin;
			ext_s2_reg   <= ext_s1_reg;
			ext_prev_reg <= ext_s2_reg;
		end
	end

	// Overflow flags: hardware set wins over a software clear
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			overflow_flag_reg <= 2'h0;
		end else begin
			for (int b = 0; b < 2; b++) begin
				if (ovf_evt[b]) begin
					overflow_flag_reg[b] <= 1'b1;
				end else if (sfr_wr && sfr_addr == cap_pkg::A_STA) begin
					overflow_flag_reg[b] <= sfr_wdata[cap_pkg::STA_OVF[b]];
				end
			end
		end
	end

	// Interrupt request, registered so the pin comes from a flop
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			overflow_irq <= 1'b0;
		end else begin
			overflow_irq <= |(overflow_flag_reg & {block_control_reg[1][cap_pkg::CTL_IRQ],
				block_control_reg[0][cap_pkg::CTL_IRQ]});
		end
	end

	generate
		for (genvar b = 0; b < 2; b++) begin : g_blk
			logic [7:0] ctl;
			logic       ovf_pt;
			assign ctl = block_control_reg[b];

			// Run gate: global start from block 0, own run bit, idle halt
			assign run[b] = (block_control_reg[0][cap_pkg::CTL_ALL]
				| ctl[cap_pkg::CTL_RUN])
				& ~(ctl[cap_pkg::CTL_IDLE] & cpu_idle);

			// Counter clock source; code 11 gives no clock at all
			always_comb begin
				unique case (ctl[cap_pkg::CTL_CLK +: 2])
					cap_pkg::CLK_PSC: tick[b] = run[b] & psc_cfg_reg[b][cap_pkg::PSC_CE]
						& ((psc_cnt_reg[b] & psc_mask(psc_cfg_reg[b][3:0]))
						== psc_mask(psc_cfg_reg[b][3:0]));
					cap_pkg::CLK_T0:  tick[b] = run[b] & timer0_ovf;
					cap_pkg::CLK_EXT: tick[b] = run[b] & ext_s2_reg[b] & ~ext_prev_reg[b];
					default:          tick[b] = 1'b0;
				endcase
			end

			// Programmable mode when any module of the block asks for it
			assign prog[b] = (mode_reg[3*b][1:0] == cap_pkg::PWM_PRG8)
				| (mode_reg[3*b+1][1:0] == cap_pkg::PWM_PRG8)
				| (mode_reg[3*b+2][1:0] == cap_pkg::PWM_PRG8);
			assign match[b]   = tick[b] & prog[b] & (cnt_reg[b][7:0] == period_act_reg[b]);
			assign lo_wrap[b] = tick[b] & ~prog[b] & (cnt_reg[b][7:0] == 8'hff);
			assign ovf_pt     = ctl[cap_pkg::CTL_TEN] ? (cnt_reg[b][9:0] == cap_pkg::TEN_MAX)
				: (cnt_reg[b] == 16'hffff);
			assign ovf_evt[b] = tick[b] & ~match[b] & ovf_pt;

			// Prescaler counter runs free on mclk
			always_ff @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					psc_cnt_reg[b] <= 15'h0;
				end else begin
					psc_cnt_reg[b] <= psc_cnt_reg[b] + 15'h1;
				end
			end

			// Control, period and prescaler registers, software only
			always_ff @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					block_control_reg[b] <= cap_pkg::CTL_RST;
					period_reg[b]        <= 8'h00;
					psc_cfg_reg[b]       <= cap_pkg::PSC_RST;
				end else if (sfr_wr) begin
					if (sfr_addr == cap_pkg::A_CTL[b]) begin
						// Bit 3 reserved; bit 7 exists only in block 0
						block_control_reg[b] <= sfr_wdata & (b == 0 ? 8'hf7 : 8'h77);
					end
					if (sfr_addr == cap_pkg::A_PER[b]) begin
						period_reg[b] <= sfr_wdata;
					end
					if (sfr_addr == cap_pkg::A_PSC[b]) begin
						psc_cfg_reg[b] <= sfr_wdata & 8'h1f;
					end
				end
			end

			// Active period is reloaded at each match, so a new period
			// takes effect only at a pulse boundary and never mid-pulse
			always_ff @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					period_act_reg[b] <= 8'h00;
				end else if (match[b] || !prog[b]) begin
					period_act_reg[b] <= period_reg[b];
				end
			end

			// Up counter; software byte writes win over counting
			always_ff @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					cnt_reg[b] <= 16'h0000;
				end else if (sfr_wr && sfr_addr == cap_pkg::A_CNTL[b]) begin
					cnt_reg[b][7:0] <= sfr_wdata;
				end else if (sfr_wr && sfr_addr == cap_pkg::A_CNTH[b]) begin
					cnt_reg[b][15:8] <= sfr_wdata;
				end else if (match[b]) begin
					cnt_reg[b] <= 16'h0000;
				end else if (tick[b] && ctl[cap_pkg::CTL_TEN]) begin
					cnt_reg[b] <= {6'h00, cnt_reg[b][9:0] + 10'h1};
				end else if (tick[b]) begin
					cnt_reg[b] <= cnt_reg[b] + 16'h1;
				end
			end

			for (genvar i = 0; i < 3; i++) begin : g_mod
				localparam int M = 3 * b + i;
				logic [1:0] pmode;
				logic       ecmp;
				logic       hi;
				assign pmode = mode_reg[M][cap_pkg::MODE_PWM +: 2];
				assign ecmp  = mode_reg[M][cap_pkg::MODE_ECMP];

				// Mode register; compare writes move the enable bit
				always_ff @(posedge mclk or negedge nrst) begin
					if (!nrst) begin
						mode_reg[M] <= cap_pkg::MODE_RST;
					end else if (sfr_wr && sfr_addr == cap_pkg::A_MODE[M]) begin
						mode_reg[M] <= sfr_wdata;
					end else if (sfr_wr && sfr_addr == cap_pkg::A_CMPL[M]) begin
						mode_reg[M][cap_pkg::MODE_ECMP] <= 1'b0;
					end else if (sfr_wr && sfr_addr == cap_pkg::A_CMPH[M]) begin
						mode_reg[M][cap_pkg::MODE_ECMP] <= 1'b1;
					end
				end

				// Compare bytes; in 8-bit modes the low byte holds the
				// active duty, refreshed from the high byte each pulse
				always_ff @(posedge mclk or negedge nrst) begin
					if (!nrst) begin
						cmp_lo_reg[M] <= 8'h00;
						cmp_hi_reg[M] <= 8'h00;
					end else begin
						if (sfr_wr && sfr_addr == cap_pkg::A_CMPH[M]) begin
							cmp_hi_reg[M] <= sfr_wdata;
						end
						if (sfr_wr && sfr_addr == cap_pkg::A_CMPL[M]) begin
							cmp_lo_reg[M] <= sfr_wdata;
						end else if (pmode == cap_pkg::PWM_FIX8 && lo_wrap[b]) begin
							cmp_lo_reg[M] <= cmp_hi_reg[M];
						end else if (pmode == cap_pkg::PWM_PRG8 && match[b]) begin
							cmp_lo_reg[M] <= cmp_hi_reg[M];
						end
					end
				end

				// Compare condition per mode; counter at zero after a wrap
				// drops the pin unless the duty is full
				always_comb begin
					unique case (pmode)
						cap_pkg::PWM_FIX8, cap_pkg::PWM_PRG8:
							hi = cnt_reg[b][7:0] >= cmp_lo_reg[M];
						cap_pkg::PWM_WIDE:
							if (ctl[cap_pkg::CTL_TEN]) begin
								hi = cnt_reg[b][9:0] >= {cmp_hi_reg[M][1:0], cmp_lo_reg[M]};
							end else begin
								hi = cnt_reg[b] >= {cmp_hi_reg[M], cmp_lo_reg[M]};
							end
						cap_pkg::PWM_OFF:
							hi = 1'b0;
					endcase
				end

				// Output pin from a flop; disabled comparator holds it low
				always_ff @(posedge mclk or negedge nrst) begin
					if (!nrst) begin
						pwm_output_pin[M] <= 1'b0;
					end else begin
						pwm_output_pin[M] <= ecmp & hi;
					end
				end

				property p_ecmp_low;
					@(posedge mclk) disable iff (!nrst)
					sfr_wr && sfr_addr == cap_pkg::A_CMPL[M] |=> !ecmp ##1 !pwm_output_pin[M];
				endproperty
				a_ecmp_low: assert property (p_ecmp_low) else $error("enable not cleared");

				property p_ecmp_high;
					@(posedge mclk) disable iff (!nrst)
					sfr_wr && sfr_addr == cap_pkg::A_CMPH[M] |=> ecmp && cmp_hi_reg[M] == $past(sfr_wdata);
				endproperty
				a_ecmp_high: assert property (p_ecmp_high) else $error("enable not set");

				property p_copy8;
					@(posedge mclk) disable iff (!nrst)
					pmode == cap_pkg::PWM_FIX8 && lo_wrap[b] && !sfr_wr
					|=> cmp_lo_reg[M] == $past(cmp_hi_reg[M]);
				endproperty
				a_copy8: assert property (p_copy8) else $error("duty not copied");

				property p_wide_ovf;
					@(posedge mclk) disable iff (!nrst)
					pmode == cap_pkg::PWM_WIDE && ovf_evt[b] && !sfr_wr
					&& (ctl[cap_pkg::CTL_TEN] ? {cmp_hi_reg[M][1:0], cmp_lo_reg[M]} != 10'h000
					: {cmp_hi_reg[M], cmp_lo_reg[M]} != 16'h0000) |=> ##1 !pwm_output_pin[M];
				endproperty
				a_wide_ovf: assert property (p_wide_ovf) else $error("pin not low at overflow");

				property p_full_duty;
					@(posedge mclk) disable iff (!nrst)
					pmode == cap_pkg::PWM_WIDE && ecmp && !ctl[cap_pkg::CTL_TEN]
					&& {cmp_hi_reg[M], cmp_lo_reg[M]} == 16'h0000 |=> pwm_output_pin[M];
				endproperty
				a_full_duty: assert property (p_full_duty) else $error("full duty not high");
			end

			property p_stopped;
				@(posedge mclk) disable iff (!nrst)
				!block_control_reg[0][cap_pkg::CTL_ALL] && !ctl[cap_pkg::CTL_RUN] && !sfr_wr
				|=> $stable(cnt_reg[b]);
			endproperty
			a_stopped: assert property (p_stopped) else $error("stopped counter moved");

			property p_idle;
				@(posedge mclk) disable iff (!nrst)
				ctl[cap_pkg::CTL_IDLE] && cpu_idle |-> !tick[b];
			endproperty
			a_idle: assert property (p_idle) else $error("counted during idle");

			property p_match;
				@(posedge mclk) disable iff (!nrst)
				match[b] && !sfr_wr |=> cnt_reg[b] == 16'h0000;
			endproperty
			a_match: assert property (p_match) else $error("no clear on period match");

			property p_ovf_flag;
				@(posedge mclk) disable iff (!nrst)
				ovf_evt[b] |=> overflow_flag_reg[b] ##1 (overflow_irq == $past(ctl[cap_pkg::CTL_IRQ]
				|| (overflow_flag_reg[1-b] && block_control_reg[1-b][cap_pkg::CTL_IRQ])));
			endproperty
			a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag lost");
		end
	endgenerate

	// Read mux; unmapped addresses and reserved bits read zero
	always_comb begin
		rd_mux = 8'h00;
		if (sfr_addr == cap_pkg::A_STA) begin
			rd_mux[cap_pkg::STA_OVF[0]] = overflow_flag_reg[0];
			rd_mux[cap_pkg::STA_OVF[1]] = overflow_flag_reg[1];
		end
		for (int b = 0; b < 2; b++) begin
			if (sfr_addr == cap_pkg::A_CTL[b]) rd_mux = block_control_reg[b];
			if (sfr_addr == cap_pkg::A_CNTL[b]) rd_mux = cnt_reg[b][7:0];
			if (sfr_addr == cap_pkg::A_CNTH[b]) rd_mux = cnt_reg[b][15:8];
			if (sfr_addr == cap_pkg::A_PER[b]) rd_mux = period_reg[b];
			if (sfr_addr == cap_pkg::A_PSC[b]) rd_mux = psc_cfg_reg[b];
		end
		for (int m = 0; m < 6; m++) begin
			if (sfr_addr == cap_pkg::A_MODE[m]) rd_mux = mode_reg[m];
			if (sfr_addr == cap_pkg::A_CMPL[m]) rd_mux = cmp_lo_reg[m];
			if (sfr_addr == cap_pkg::A_CMPH[m]) rd_mux = cmp_hi_reg[m];
		end
	end

	// Read data is captured on the read strobe and held until the next
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			sfr_rdata <= rd_mux;
		end
	end
endmodule // cap_pwm_unit

/* File: tb/cap_pwm_load.sv */
/*
 Load model on the six PWM output pins: counts high cycles per pin.
 Assumes the bench pulses clr, then holds meas for the window.
*/
`timescale 1ns/10ps
module cap_pwm_load (
	input  wire logic        mclk,
	input  wire logic        clr,
	input  wire logic        meas,
	input  wire logic [5:0]  pin,
	output logic      [15:0] hi_cnt [6]
);
	// Counting high cycles makes the result independent of pulse phase
	always_ff @(posedge mclk) begin
		for (int i = 0; i < 6; i++) begin
			if (clr)
				hi_cnt[i] <= 16'h0000;
			else if (meas)
				hi_cnt[i] <= hi_cnt[i] + {15'h0000, pin[i]};
		end
	end
endmodule // cap_pwm_load

/* File: tb/cap_pwm_unit_tb_top.sv */
/*
 Self-checking bench for the PWM unit: register tasks, duty windows.
 Assumes the load model counts pins; prescaler resets to divide by 1.
*/
`timescale 1ns/10ps
module cap_pwm_unit_tb_top;
	logic        mclk        = 1'b0;
	logic        nrst        = 1'b0;
	logic [7:0]  sfr_addr    = 8'h00;
	logic [7:0]  sfr_wdata   = 8'h00;
	logic        sfr_wr      = 1'b0;
	logic        sfr_rd      = 1'b0;
	logic [7:0]  sfr_rdata;
	logic        cpu_idle    = 1'b0;
	logic        timer0_ovf  = 1'b0;
	logic [1:0]  ext_clk_pin = 2'h0;
	logic [5:0]  pwm_output_pin;
	logic        overflow_irq;
	logic        clr         = 1'b0;
	logic        meas        = 1'b0;
	logic [15:0] hi_cnt [6];
	logic [7:0]  v;
	logic [7:0]  w;
	int          n_errors        = 0;
	int          samples_checked = 0;

	// 40 MHz clock
	always #12.5 mclk = ~mclk;

	cap_pwm_unit cap_pwm_unit_inst (
		.mclk(mclk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .cpu_idle(cpu_idle),
		.timer0_ovf(timer0_ovf), .ext_clk_pin(ext_clk_pin),
		.pwm_output_pin(pwm_output_pin), .overflow_irq(overflow_irq)
	);

	cap_pwm_load cap_pwm_load_inst (
		.mclk(mclk), .clr(clr), .meas(meas), .pin(pwm_output_pin), .hi_cnt(hi_cnt)
	);

	// Verdict in one place, shared with the watchdog
	task automatic end_of_test;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Inputs always change 1 ns after the rising edge
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// Strobe drops for a cycle between calls, so no same-step toggle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		step(1);
		sfr_wr = 1'b0;
		step(1);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		sfr_addr = a;
		sfr_rd = 1'b1;
		step(1);
		sfr_rd = 1'b0;
		d = sfr_rdata;
		step(1);
	endtask

	task automatic chkr(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk({8'h00, d}, {8'h00, e});
	endtask

	// Low byte first, high byte arms the comparator
	task automatic cmp(input int m, input logic [7:0] lo, input logic [7:0] hi);
		wr(cap_pkg::A_CMPL[m], lo);
		wr(cap_pkg::A_CMPH[m], hi);
	endtask

	// High-cycle counts of modules 0..2 over a window of n cycles
	task automatic window(input int n, input logic [15:0] e0, e1, e2);
		clr = 1'b1;
		step(1);
		clr = 1'b0;
		meas = 1'b1;
		step(n);
		meas = 1'b0;
		chk(hi_cnt[0], e0);
		chk(hi_cnt[1], e1);
		chk(hi_cnt[2], e2);
	endtask

	// Main sequence
	initial begin
		step(6);
		nrst = 1'b1;
		chk({10'h000, pwm_output_pin}, 16'h0000);
		chkr(cap_pkg::A_CTL[0], cap_pkg::CTL_RST);
		chkr(cap_pkg::A_CTL[1], 8'h00);
		chkr(8'h80, 8'h00);
		wr(cap_pkg::A_CTL[1], 8'hff);
		chkr(cap_pkg::A_CTL[1], 8'h77);
		wr(cap_pkg::A_CTL[0], 8'hff);
		chkr(cap_pkg::A_CTL[0], 8'hf7);
		wr(cap_pkg::A_CTL[0], 8'h00);
		wr(cap_pkg::A_CTL[1], 8'h00);
		// Comparator enable follows compare byte writes
		wr(cap_pkg::A_MODE[0], 8'h03);
		wr(cap_pkg::A_CMPL[0], 8'hf0);
		chkr(cap_pkg::A_MODE[0], 8'h03);
		wr(cap_pkg::A_CMPH[0], 8'hff);
		chkr(cap_pkg::A_MODE[0], 8'h43);
		wr(cap_pkg::A_MODE[1], 8'h03);
		cmp(1, 8'h00, 8'h00);
		wr(cap_pkg::A_MODE[2], 8'h03);
		wr(cap_pkg::A_CMPL[2], 8'h00);
		// Ten-bit PWM, upper compare bits set but ignored
		wr(cap_pkg::A_CTL[0], 8'h64);
		step(1100);
		window(1024, 16'd16, 16'd1024, 16'd0);
		chk({15'h0000, overflow_irq}, 16'h0001);
		chkr(cap_pkg::A_STA, 8'h08);
		wr(cap_pkg::A_PSC[0], 8'h11);
		step(2100);
		window(2048, 16'd32, 16'd2048, 16'd0);
		wr(cap_pkg::A_PSC[0], 8'h10);
		// Eight-bit fixed frequency
		wr(cap_pkg::A_CTL[0], 8'h40);
		wr(cap_pkg::A_MODE[0], 8'h01);
		cmp(0, 8'h00, 8'hc0);
		wr(cap_pkg::A_MODE[1], 8'h01);
		cmp(1, 8'h00, 8'h10);
		wr(cap_pkg::A_MODE[2], 8'h00);
		step(600);
		window(1024, 16'd256, 16'd960, 16'd0);
		// Programmable frequency, shared period, own duties
		wr(cap_pkg::A_PER[0], 8'h7f);
		wr(cap_pkg::A_MODE[0], 8'h02);
		cmp(0, 8'h00, 8'h40);
		wr(cap_pkg::A_MODE[1], 8'h02);
		cmp(1, 8'h00, 8'h20);
		step(600);
		window(1024, 16'd512, 16'd768, 16'd0);
		// Sixteen-bit PWM started just below the top, through the overflow
		wr(cap_pkg::A_CTL[0], 8'h00);
		wr(cap_pkg::A_MODE[0], 8'h03);
		cmp(0, 8'h80, 8'hff);
		wr(cap_pkg::A_MODE[1], 8'h03);
		cmp(1, 8'h00, 8'h00);
		wr(cap_pkg::A_CNTL[0], 8'h00);
		wr(cap_pkg::A_CNTH[0], 8'hff);
		wr(cap_pkg::A_CTL[0], 8'h40);
		window(300, 16'd128, 16'd300, 16'd0);
		chk({15'h0000, pwm_output_pin[0]}, 16'h0000);
		// Timer 0 overflow and external pin as counter clock
		wr(cap_pkg::A_CTL[0], 8'h00);
		wr(cap_pkg::A_CNTL[0], 8'h00);
		wr(cap_pkg::A_CTL[0], 8'h41);
		repeat (5) begin
			timer0_ovf = 1'b1;
			step(1);
			timer0_ovf = 1'b0;
			step(1);
		end
		chkr(cap_pkg::A_CNTL[0], 8'h05);
		wr(cap_pkg::A_CTL[0], 8'h00);
		wr(cap_pkg::A_CNTL[0], 8'h00);
		wr(cap_pkg::A_CTL[0], 8'h42);
		repeat (3) begin
			ext_clk_pin = 2'h1;
			step(4);
			ext_clk_pin = 2'h0;
			step(4);
		end
		chkr(cap_pkg::A_CNTL[0], 8'h03);
		// Idle halt freezes the counter
		wr(cap_pkg::A_CTL[0], 8'h50);
		cpu_idle = 1'b1;
		step(2);
		rd(cap_pkg::A_CNTL[0], v);
		chkr(cap_pkg::A_CNTL[0], v);
		cpu_idle = 1'b0;
		rd(cap_pkg::A_CNTL[0], v);
		rd(cap_pkg::A_CNTL[0], w);
		chk({15'h0000, w !== v}, 16'h0001);
		// Block 0 start-all runs block 1 without its own run bit
		wr(cap_pkg::A_CTL[0], 8'h80);
		rd(cap_pkg::A_CNTL[1], v);
		rd(cap_pkg::A_CNTL[1], w);
		chk({15'h0000, w !== v}, 16'h0001);
		wr(cap_pkg::A_CTL[0], 8'h00);
		step(2);
		rd(cap_pkg::A_CNTL[1], v);
		chkr(cap_pkg::A_CNTL[1], v);
		// Flag set by software, masked, then cleared
		wr(cap_pkg::A_STA, 8'h00);
		wr(cap_pkg::A_STA, 8'h08);
		wr(cap_pkg::A_CTL[0], 8'h20);
		step(1);
		chk({15'h0000, overflow_irq}, 16'h0001);
		wr(cap_pkg::A_CTL[0], 8'h00);
		step(1);
		chk({15'h0000, overflow_irq}, 16'h0000);
		chkr(cap_pkg::A_STA, 8'h08);
		wr(cap_pkg::A_STA, 8'h00);
		chkr(cap_pkg::A_STA, 8'h00);
		end_of_test;
	end

	// Watchdog well beyond the roughly 10000 cycles the tests need
	initial begin
		#(25 * 30000);
		n_errors++;
		end_of_test;
	end
endmodule // cap_pwm_unit_tb_top
